// File: design/lssh_link_if.sv
// Interface: one 8-byte service frame in each direction between the two ends
`default_nettype none
interface lssh_link_if;
  logic        req_valid;
  logic [10:0] req_id;
  logic [3:0]  req_dlc;
  logic [63:0] req_data;
  logic        rsp_valid;
  logic [10:0] rsp_id;
  logic [3:0]  rsp_dlc;
  logic [63:0] rsp_data;
  modport slave  (input req_valid, req_id, req_dlc, req_data,
                  output rsp_valid, rsp_id, rsp_dlc, rsp_data);
  modport master (output req_valid, req_id, req_dlc, req_data,
                  input rsp_valid, rsp_id, rsp_dlc, rsp_data);
endinterface
`default_nettype wire

// File: design/lssh_master.sv
// Master end: sends one request frame per command and returns each response frame with the response id and eight data bytes
`default_nettype none
module lssh_master
  import lssh_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  lssh_link_if.master      link,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [55:0] cmd_payload,
  output logic             rsp_out_valid,
  output logic [63:0]      rsp_out_data
);
  typedef struct packed {
    logic        req_valid;
    logic [63:0] req_data;
    logic        rsp_valid;
    logic [63:0] rsp_data;
  } lssh_mst_t;

  lssh_mst_t st_reg;
  lssh_mst_t st_next;

  // Requests go out in one cycle, so the master can always take a command
  assign cmd_ready     = 1'b1;
  assign link.req_valid = st_reg.req_valid;
  assign link.req_id    = LSSH_ID_REQ;
  assign link.req_dlc   = LSSH_DLC;
  assign link.req_data  = st_reg.req_data;
  assign rsp_out_valid  = st_reg.rsp_valid;
  assign rsp_out_data   = st_reg.rsp_data;

  // Payload is placed as bytes 1..7 with byte 0 the command
  always_comb begin
    st_next           = st_reg;
    st_next.req_valid = cmd_valid;
    if (cmd_valid) begin
      st_next.req_data = {cmd_payload, cmd_code};
    end
    st_next.rsp_valid = link.rsp_valid && link.rsp_id == LSSH_ID_RSP
                        && link.rsp_dlc == LSSH_DLC;
    if (st_next.rsp_valid) begin
      st_next.rsp_data = link.rsp_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  // are left to the command source driving this end
endmodule
`default_nettype wire

// File: design/lssh_pkg.sv
// Package: frame constants, command codes and timing for the layer-settings service handler
`default_nettype none
package lssh_pkg;
  localparam logic [10:0] LSSH_ID_REQ        = 11'h7e5;
  localparam logic [10:0] LSSH_ID_RSP        = 11'h7e4;
  localparam logic [3:0]  LSSH_DLC           = 4'h8;
  localparam logic [7:0]  LSSH_CS_ACT_RATE   = 8'h51;
  localparam logic [7:0]  LSSH_CS_STORE      = 8'h17;
  localparam logic [7:0]  LSSH_CS_INQ_VENDOR = 8'h5a;
  localparam logic [7:0]  LSSH_CS_INQ_PROD   = 8'h5b;
  localparam logic [7:0]  LSSH_CS_INQ_REV    = 8'h5c;
  localparam logic [7:0]  LSSH_CS_INQ_SER    = 8'h5d;
  localparam logic [7:0]  LSSH_CS_INQ_NODE   = 8'h5e;
  localparam logic [7:0]  LSSH_CS_ID_VENDOR  = 8'h46;
  localparam logic [7:0]  LSSH_CS_ID_PROD    = 8'h47;
  localparam logic [7:0]  LSSH_CS_ID_REV_LO  = 8'h48;
  localparam logic [7:0]  LSSH_CS_ID_REV_HI  = 8'h49;
  localparam logic [7:0]  LSSH_CS_ID_SER_LO  = 8'h4a;
  localparam logic [7:0]  LSSH_CS_ID_SER_HI  = 8'h4b;
  localparam logic [7:0]  LSSH_CS_ID_REPLY   = 8'h4f;
  localparam logic [7:0]  LSSH_ERR_OK        = 8'h00;
  localparam logic [7:0]  LSSH_ERR_NVM       = 8'h02;
  // One millisecond at the 125 MHz system clock
  localparam int          LSSH_CLK_MHZ       = 125;
  localparam int          LSSH_MS_US         = 1000;
  localparam int          LSSH_MS_CYCLES     = LSSH_CLK_MHZ * LSSH_MS_US;
  typedef logic [63:0] lssh_frame_t;
endpackage
`default_nettype wire

// File: design/lssh_slave.sv
// Slave end: interprets layer-settings requests and builds the answers
//
// How it works
// - 0x51 switches rate after carried delay
// - Wait delay once, then adopt rate
// - Wait delay again before any transmit
// - 0x17 stores node-ID only, not the rate
// - Store answer 0x17, error 00 or 02
// - Master keeps only one slave configuring; lssh_master leaves this to its command source
// - 0x5A returns vendor identity
// - 0x5B returns product code
// - 0x5C returns revision number
// - 0x5D returns serial number
// - 0x5E returns current node-ID
// - 0x46/0x47 give vendor, product match
// - 0x48/0x49 give revision range
// - 0x4A/0x4B give serial range
// - Matching slave replies 0x4F
// - Master narrows ranges to one slave; lssh_master leaves this to its command source
// - Stored values apply after restart
// - Request id 0x7E5, response 0x7E4
// - Eight data bytes, byte 0 command
// - Act only in configuration mode, except 0x46-0x4B identify
`default_nettype none
module lssh_slave
  import lssh_pkg::*;
#(
  parameter int MS_CYCLES = LSSH_MS_CYCLES
)(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  lssh_link_if.slave       link,
  input  wire logic        cfg_mode,
  input  wire logic [31:0] id_vendor,
  input  wire logic [31:0] id_product,
  input  wire logic [31:0] id_revision,
  input  wire logic [31:0] id_serial,
  input  wire logic [7:0]  node_id_cur,
  output logic             rate_switch,
  output logic             tx_allowed,
  output logic             nvm_req,
  output logic [7:0]       nvm_node_id,
  input  wire logic        nvm_done,
  input  wire logic        nvm_fail
);
  typedef enum logic [3:0] {
    LSSH_IDLE  = 4'b0001,
    LSSH_DLY1  = 4'b0010,
    LSSH_DLY2  = 4'b0100,
    LSSH_STORE = 4'b1000
  } lssh_state_t;

  typedef struct packed {
    lssh_state_t state;
    logic [31:0] tick;
    logic [15:0] ms_left;
    logic [15:0] delay;
    logic        rsp_valid;
    logic [63:0] rsp_data;
    logic        rate_switch;
    logic        tx_allowed;
    logic        nvm_req;
    logic [7:0]  nvm_node_id;
    logic [31:0] m_vendor;
    logic [31:0] m_product;
    logic [31:0] rev_lo;
    logic [31:0] rev_hi;
    logic [31:0] ser_lo;
    logic [31:0] ser_hi;
  } lssh_slv_t;

  lssh_slv_t st_reg;
  lssh_slv_t st_next;

  logic        req_ok;
  logic [7:0]  cs;
  logic [31:0] val;
  logic        id_match;

  function automatic logic [63:0] lssh_word(input logic [7:0] code, input logic [31:0] v);
    lssh_word = {24'h0, v, code};
  endfunction

  // --------------------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------------------
  assign req_ok = link.req_valid && link.req_id == LSSH_ID_REQ
                  && link.req_dlc == LSSH_DLC;
  assign cs     = link.req_data[7:0];
  assign val    = link.req_data[39:8];
  // All stored fields but the serial upper bound, which comes with the closing request
  assign id_match = id_vendor == st_reg.m_vendor && id_product == st_reg.m_product
                    && id_revision >= st_reg.rev_lo && id_revision <= st_reg.rev_hi
                    && id_serial >= st_reg.ser_lo;

  assign link.rsp_valid = st_reg.rsp_valid;
  assign link.rsp_id    = LSSH_ID_RSP;
  assign link.rsp_dlc   = LSSH_DLC;
  assign link.rsp_data  = st_reg.rsp_data;
  assign rate_switch    = st_reg.rate_switch;
  assign tx_allowed     = st_reg.tx_allowed;
  assign nvm_req        = st_reg.nvm_req;
  assign nvm_node_id    = st_reg.nvm_node_id;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_next             = st_reg;
    st_next.rsp_valid   = 1'b0;
    st_next.rate_switch = 1'b0;
    st_next.nvm_req     = 1'b0;
    case (st_reg.state)
      LSSH_IDLE: begin
        if (req_ok) begin
          case (cs)
            LSSH_CS_ACT_RATE: begin
              // A configuration service: a slave in wait mode keeps its rate
              if (cfg_mode) begin
                st_next.delay      = link.req_data[23:8];
                st_next.ms_left    = link.req_data[23:8];
                st_next.tick       = '0;
                st_next.tx_allowed = 1'b0;
                st_next.state      = LSSH_DLY1;
              end
            end
            LSSH_CS_ID_VENDOR: st_next.m_vendor  = val;
            LSSH_CS_ID_PROD:   st_next.m_product = val;
            LSSH_CS_ID_REV_LO: st_next.rev_lo    = val;
            LSSH_CS_ID_REV_HI: st_next.rev_hi    = val;
            LSSH_CS_ID_SER_LO: st_next.ser_lo    = val;
            LSSH_CS_ID_SER_HI: begin
              st_next.ser_hi = val;
              // Serial high closes the sequence, so match is judged now
              if (id_match && id_serial <= val) begin
                st_next.rsp_valid = 1'b1;
                st_next.rsp_data  = lssh_word(LSSH_CS_ID_REPLY, 32'h0);
              end
            end
            default: begin
              if (cfg_mode) begin
                st_next.rsp_valid = 1'b1;
                case (cs)
                  LSSH_CS_STORE: begin
                    st_next.rsp_valid   = 1'b0;
                    st_next.nvm_req     = 1'b1;
                    st_next.nvm_node_id = node_id_cur;
                    st_next.state       = LSSH_STORE;
                  end
                  LSSH_CS_INQ_VENDOR: st_next.rsp_data = lssh_word(cs, id_vendor);
                  LSSH_CS_INQ_PROD:   st_next.rsp_data = lssh_word(cs, id_product);
                  LSSH_CS_INQ_REV:    st_next.rsp_data = lssh_word(cs, id_revision);
                  LSSH_CS_INQ_SER:    st_next.rsp_data = lssh_word(cs, id_serial);
                  LSSH_CS_INQ_NODE:   st_next.rsp_data = lssh_word(cs, {24'h0, node_id_cur});
                  default:            st_next.rsp_valid = 1'b0;
                endcase
              end
            end
          endcase
        end
      end
      LSSH_DLY1, LSSH_DLY2: begin
        if (st_reg.ms_left == 16'h0) begin
          st_next.tick = '0;
          if (st_reg.state == LSSH_DLY1) begin
            st_next.rate_switch = 1'b1;
            st_next.ms_left     = st_reg.delay;
            st_next.state       = LSSH_DLY2;
          end else begin
            st_next.tx_allowed = 1'b1;
            st_next.state      = LSSH_IDLE;
          end
        end else if (st_reg.tick == 32'(MS_CYCLES - 1)) begin
          st_next.tick    = '0;
          st_next.ms_left = st_reg.ms_left - 16'h1;
        end else begin
          st_next.tick = st_reg.tick + 32'h1;
        end
      end
      LSSH_STORE: begin
        if (nvm_done) begin
          st_next.rsp_valid = 1'b1;
          st_next.rsp_data  = lssh_word(LSSH_CS_STORE,
                                        {24'h0, nvm_fail ? LSSH_ERR_NVM : LSSH_ERR_OK});
          st_next.state     = LSSH_IDLE;
        end
      end
      default: st_next.state = LSSH_IDLE;
    endcase
    // No frame leaves while a bit-rate switch is in progress
    if (!st_next.tx_allowed) begin
      st_next.rsp_valid = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg            <= '0;
      st_reg.state      <= LSSH_IDLE;
      st_reg.tx_allowed <= 1'b1;
      st_reg.rev_hi     <= '1;
      st_reg.ser_hi     <= '1;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

// File: test/lssh_link_sva.sv
// Checker: timing and content rules on the service link
`default_nettype none
module lssh_link_sva
  import lssh_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        req_valid,
  input wire logic [10:0] req_id,
  input wire logic [3:0]  req_dlc,
  input wire logic [63:0] req_data,
  input wire logic        rsp_valid,
  input wire logic [10:0] rsp_id,
  input wire logic [3:0]  rsp_dlc,
  input wire logic [63:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] req_cmd;
  logic [7:0] rsp_cmd;
  assign req_cmd = req_data[7:0];
  assign rsp_cmd = rsp_data[7:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_req_frame_ok: assert property (req_valid |-> req_id == LSSH_ID_REQ && req_dlc == LSSH_DLC)
    else $error("request frame header wrong");
  a_rsp_id_fixed: assert property (rsp_valid |-> rsp_id == LSSH_ID_RSP)
    else $error("response id wrong");
  a_rsp_dlc_eight: assert property (rsp_valid |-> rsp_dlc == LSSH_DLC)
    else $error("response length wrong");
  a_rsp_cmd_known: assert property (rsp_valid |-> rsp_cmd inside {8'h17, [8'h5a:8'h5e], 8'h4f})
    else $error("reply with unsupported command");
  a_inq_echo_next: assert property (rsp_valid && rsp_cmd inside {[8'h5a:8'h5e]}
    |-> $past(req_valid) && $past(req_cmd) == rsp_cmd)
    else $error("inquiry reply not one cycle after its request");
  a_inq_pad_zero: assert property (rsp_valid && rsp_cmd inside {[8'h5a:8'h5d]}
    |-> rsp_data[63:40] == 24'h0)
    else $error("identity reply padding not zero");
  a_node_pad_zero: assert property (rsp_valid && rsp_cmd == 8'h5e |-> rsp_data[63:16] == 48'h0)
    else $error("node reply padding not zero");
  a_ident_after_hi: assert property (rsp_valid && rsp_cmd == 8'h4f
    |-> $past(req_cmd) == LSSH_CS_ID_SER_HI && $past(req_valid) && rsp_data[63:8] == 56'h0)
    else $error("identify reply without serial bound");
  a_store_err_code: assert property (rsp_valid && rsp_cmd == 8'h17
    |-> rsp_data[15:8] inside {8'h00, 8'h02} && rsp_data[63:16] == 48'h0)
    else $error("store reply code wrong");
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Testbench: master and slave joined, driven from the command side
`default_nettype none
module tb_top;
  import lssh_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 4;
  logic        clk, sys_rst, cmd_valid, cmd_ready, rsp_out_valid, cfg_mode;
  logic        rate_switch, tx_allowed, nvm_req, nvm_done, nvm_fail;
  logic [7:0]  cmd_code, node_id_cur, nvm_node_id;
  logic [55:0] cmd_payload;
  logic [63:0] rsp_out_data;
  logic [31:0] id_vendor, id_product, id_revision, id_serial, seed;
  int          fail_count, total_checks, n;
  logic [7:0]  junk [4] = '{8'h04, 8'h11, 8'h13, 8'h40};
  lssh_link_if link();
  lssh_master u_lssh_master(.clk(clk), .sys_rst(sys_rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_payload(cmd_payload),
    .rsp_out_valid(rsp_out_valid), .rsp_out_data(rsp_out_data));
  lssh_slave #(.MS_CYCLES(MS)) u_lssh_slave(.clk(clk), .sys_rst(sys_rst), .link(link),
    .cfg_mode(cfg_mode), .id_vendor(id_vendor), .id_product(id_product),
    .id_revision(id_revision), .id_serial(id_serial), .node_id_cur(node_id_cur),
    .rate_switch(rate_switch), .tx_allowed(tx_allowed), .nvm_req(nvm_req),
    .nvm_node_id(nvm_node_id), .nvm_done(nvm_done), .nvm_fail(nvm_fail));
  lssh_link_sva u_lssh_link_sva(.clk(clk), .sys_rst(sys_rst), .req_valid(link.req_valid),
    .req_id(link.req_id), .req_dlc(link.req_dlc), .req_data(link.req_data),
    .rsp_valid(link.rsp_valid), .rsp_id(link.rsp_id), .rsp_dlc(link.rsp_dlc),
    .rsp_data(link.rsp_data));
  always #4 clk = ~clk;
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [63:0] inq(input logic [7:0] c);
    case (c)
      8'h5a:   return {24'h0, id_vendor, c};
      8'h5b:   return {24'h0, id_product, c};
      8'h5c:   return {24'h0, id_revision, c};
      8'h5d:   return {24'h0, id_serial, c};
      default: return {48'h0, node_id_cur, c};
    endcase
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic send(input logic [7:0] c, input logic [55:0] p);
    @(posedge clk);
    #1 cmd_valid = 1'b1;
    cmd_code = c;
    cmd_payload = p;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
  endtask
  // Waits a bounded time; with want low the full wait is the expected outcome
  task automatic expect_rsp(input bit want, input logic [63:0] exp);
    int k;
    k = 0;
    while (k < 12 && rsp_out_valid !== 1'b1) begin
      @(posedge clk);
      #1 k++;
    end
    chk(64'(rsp_out_valid === 1'b1), 64'(want));
    if (want) chk(rsp_out_data, exp);
  endtask
  task automatic wait_hi(ref logic s);
    n = 0;
    while (n < 40 && s !== 1'b1) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 40) begin
      fail_count++;
      conclude();
    end
  endtask
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
  initial begin
    {clk, cmd_valid, nvm_done, nvm_fail, cmd_code, cmd_payload} = '0;
    {sys_rst, cfg_mode} = 2'b11;
    {fail_count, total_checks, seed} = {32'd0, 32'd0, 32'd23};
    id_vendor = xs();
    id_product = xs();
    id_revision = xs() >> 1;
    id_serial = xs() | 32'h1;
    node_id_cur = 8'(xs());
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk(64'(cmd_ready), 64'h1);
    for (int c = 8'h5a; c <= 8'h5e; c++) begin
      send(8'(c), 56'h0);
      expect_rsp(1'b1, inq(8'(c)));
    end
    // Corner codes after the inquiries: four services of the protocol that this end leaves out, then four random codes with bit 7 set
    for (int i = 0; i < 8; i++) begin
      send((i < 4) ? junk[i[1:0]] : (8'(xs()) | 8'h80), 56'h0);
      expect_rsp(1'b0, 64'h0);
    end
    cfg_mode = 1'b0;
    send(LSSH_CS_INQ_VENDOR, 56'h0);
    expect_rsp(1'b0, 64'h0);
    $display("end inquiry");
    for (int i = 0; i < 4; i++) begin
      send(LSSH_CS_ID_VENDOR, 56'(id_vendor ^ 32'(i == 3)));
      send(LSSH_CS_ID_PROD, 56'(id_product));
      send(LSSH_CS_ID_REV_LO, 56'(id_revision + 32'(i == 2)));
      send(LSSH_CS_ID_REV_HI, 56'(id_revision));
      send(LSSH_CS_ID_SER_LO, 56'(id_serial));
      send(LSSH_CS_ID_SER_HI, 56'(id_serial - 32'(i == 1)));
      expect_rsp(i == 0, {56'h0, LSSH_CS_ID_REPLY});
    end
    $display("end identify");
    send(LSSH_CS_ACT_RATE, 56'h1);
    expect_rsp(1'b0, 64'h0);
    chk(64'(tx_allowed), 64'h1);
    cfg_mode = 1'b1;
    for (int f = 0; f < 2; f++) begin
      send(LSSH_CS_STORE, 56'h0);
      wait_hi(nvm_req);
      chk(64'(nvm_node_id), 64'(node_id_cur));
      nvm_done = 1'b1;
      nvm_fail = f[0];
      @(posedge clk);
      #1 nvm_done = 1'b0;
      expect_rsp(1'b1, {48'h0, (f == 1) ? LSSH_ERR_NVM : LSSH_ERR_OK, LSSH_CS_STORE});
    end
    $display("end store");
    send(LSSH_CS_ACT_RATE, 56'h2);
    wait_hi(rate_switch);
    chk(64'(n >= 2 * MS && n <= 2 * MS + 3), 64'h1);
    chk(64'(tx_allowed), 64'h0);
    wait_hi(tx_allowed);
    chk(64'(n >= 2 * MS - 1 && n <= 2 * MS + 2), 64'h1);
    $display("end rate switch");
    conclude();
  end
endmodule
`default_nettype wire
